// File: ccis_core.sv
// instruction semantics core with data memory, reached over apb
`timescale 1ns/10ps
`include "ccis_defines.svh"

// Notes on behaviour
// - working, pointer and stack registers are bytes
// - 15-bit counter, high and low parts
// - flags: carry, half carry, interrupt enable
// - register operands live at f0 to ff
// - source: direct, either pointer, or immediate
// - add puts sum into working register
// - add with carry, half carry updated
// - subtract with carry sets both carries
// - and immediate skips next when zero
// - memory equals immediate runs next
// - working equals source runs next
// - working differs from source runs next
// - working greater than source runs next
// - first pointer low nibble differs runs next
// - decrement register, skip next on zero
// - set chosen bit zero to seven
// - chosen bit one runs next
// - clear soft pending flag
// - swap working register with second pointer byte
// - load working register via second pointer
// - pointer forms may step pointer afterwards
module ccis_core
    import ccis_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] acc_r;
    logic [7:0] b_r;
    logic [7:0] x_r;
    logic [7:0] sp_r;
    logic [6:0] pch_r;
    logic [7:0] pcl_r;
    logic c_r;
    logic hc_r;
    logic gie_r;
    logic spnd_r;
    logic [7:0] madr_r;
    logic [1:0] skl_r;
    logic skipped_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [7:0] mem_r [0:255];

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // pointer and stack locations read from their registers, not the array
    function automatic logic [7:0] rd_mem(input logic [7:0] a);
        if (a == `CCIS_X_LOC) begin
            return x_r;
        end else if (a == `CCIS_SP_LOC) begin
            return sp_r;
        end else if (a == `CCIS_B_LOC) begin
            return b_r;
        end
        return mem_r[a];
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] r);
        return a == ADDR_W'(r);
    endfunction

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    logic exec;
    ccis_op_t op;
    ccis_src_t src;
    logic [7:0] adr;
    logic [7:0] imm;
    logic [2:0] bsel;
    logic [7:0] ea;
    logic [7:0] src_val;
    logic [7:0] reg_loc;
    logic [7:0] alu_sum;
    logic alu_c;
    logic alu_hc;

    assign exec = psel && penable && pready_r && pwrite && hit(paddr, `CCIS_CMD_ADDR);
    assign op = ccis_op_t'(pwdata[`CCIS_F_OP]);
    assign src = ccis_src_t'(pwdata[`CCIS_F_SRC]);
    assign adr = pwdata[`CCIS_F_ADR];
    assign imm = pwdata[`CCIS_F_IMM];
    assign bsel = pwdata[`CCIS_F_BIT];
    assign reg_loc = {`CCIS_REG_PAGE, adr[3:0]};

    always_comb begin
        case (src)
            CCIS_SRC_PTR_B: ea = b_r;
            CCIS_SRC_PTR_X: ea = x_r;
            default: ea = adr;
        endcase
        // a continuous assign would miss memory writes read inside the function
        src_val = (src == CCIS_SRC_IMM) ? imm : rd_mem(ea);
    end

    ccis_alu u_alu (
        .a(acc_r),
        .b(src_val),
        .cin((op == CCIS_OP_ADD) ? 1'b0 : c_r),
        .sub(op == CCIS_OP_SUBTRACT_WITH_BORROW),
        .sum(alu_sum),
        .cout(alu_c),
        .hcout(alu_hc)
    );

    // ----------------------------------------
    // execution results
    // ----------------------------------------
    logic [7:0] acc_nxt;
    logic c_nxt;
    logic hc_nxt;
    logic skip;
    logic mw_en;
    logic [7:0] mw_addr;
    logic [7:0] mw_data;
    logic [7:0] dec_val;
    logic [7:0] bit_src;

    always_comb begin
        acc_nxt = acc_r;
        c_nxt = c_r;
        hc_nxt = hc_r;
        skip = 1'b0;
        mw_en = 1'b0;
        mw_addr = ea;
        mw_data = 8'h00;
        dec_val = rd_mem(reg_loc) - 8'h01;
        bit_src = (src == CCIS_SRC_IMM) ? acc_r : rd_mem(ea);
        case (op)
            CCIS_OP_ADD: begin
                acc_nxt = alu_sum;
            end
            CCIS_OP_ADC, CCIS_OP_SUBTRACT_WITH_BORROW: begin
                acc_nxt = alu_sum;
                c_nxt = alu_c;
                hc_nxt = alu_hc;
            end
            CCIS_OP_AND: begin
                acc_nxt = acc_r & src_val;
            end
            CCIS_OP_ANDSKIP: begin
                skip = (acc_r & imm) == 8'h00;
            end
            CCIS_OP_TEQ_MI: begin
                skip = rd_mem(adr) != imm;
            end
            CCIS_OP_TEQ: begin
                skip = acc_r != src_val;
            end
            CCIS_OP_TNE: begin
                skip = acc_r == src_val;
            end
            CCIS_OP_TGT: begin
                skip = !(acc_r > src_val);
            end
            CCIS_OP_TPTR: begin
                skip = b_r[3:0] == imm[3:0];
            end
            CCIS_OP_DSZ: begin
                mw_en = 1'b1;
                mw_addr = reg_loc;
                mw_data = dec_val;
                skip = dec_val == 8'h00;
            end
            CCIS_OP_SBIT: begin
                mw_en = 1'b1;
                mw_data = rd_mem(ea) | (8'h01 << bsel);
            end
            CCIS_OP_TBIT: begin
                skip = !bit_src[bsel];
            end
            CCIS_OP_XCH: begin
                acc_nxt = rd_mem(ea);
                mw_en = 1'b1;
                mw_data = acc_r;
            end
            CCIS_OP_LOAD: begin
                acc_nxt = src_val;
            end
            default: begin
                skip = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // working register and flags
    // ----------------------------------------
    logic bus_wr;
    assign bus_wr = psel && penable && pready_r && pwrite;

    always_ff @(posedge clk) begin
        if (reset) begin
            acc_r <= 8'h00;
        end else if (exec) begin
            acc_r <= acc_nxt;
        end else if (bus_wr && hit(paddr, `CCIS_ACC_ADDR)) begin
            acc_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            c_r <= 1'b0;
            hc_r <= 1'b0;
            gie_r <= 1'b0;
            spnd_r <= 1'b0;
        end else if (exec) begin
            c_r <= c_nxt;
            hc_r <= hc_nxt;
            if (op == CCIS_OP_CLRPND) begin
                spnd_r <= 1'b0;
            end
        end else if (bus_wr && hit(paddr, `CCIS_FLG_ADDR)) begin
            c_r <= pwdata[`CCIS_FLG_C];
            hc_r <= pwdata[`CCIS_FLG_HC];
            gie_r <= pwdata[`CCIS_FLG_GIE];
            spnd_r <= pwdata[`CCIS_FLG_SPND];
        end
    end

    // ----------------------------------------
    // data memory and pointers
    // ----------------------------------------
    logic sw_mem;
    logic [7:0] wa;
    logic [7:0] wd;
    logic wen;
    logic step_b;
    logic step_x;
    logic [7:0] step_d;

    assign sw_mem = bus_wr && hit(paddr, `CCIS_MDAT_ADDR);
    assign wen = (exec && mw_en) || sw_mem;
    assign wa = exec ? mw_addr : madr_r;
    assign wd = exec ? mw_data : pwdata[7:0];
    // only load and exchange through a pointer may step it
    assign step_b = exec && pwdata[`CCIS_F_STEP] && src == CCIS_SRC_PTR_B
        && (op == CCIS_OP_LOAD || op == CCIS_OP_XCH);
    assign step_x = exec && pwdata[`CCIS_F_STEP] && src == CCIS_SRC_PTR_X
        && (op == CCIS_OP_LOAD || op == CCIS_OP_XCH);
    assign step_d = pwdata[`CCIS_F_DOWN] ? 8'hff : 8'h01;

    // data bytes carry no reset; software initialises what it uses
    always_ff @(posedge clk) begin
        if (wen && wa != `CCIS_X_LOC && wa != `CCIS_SP_LOC && wa != `CCIS_B_LOC) begin
            mem_r[wa] <= wd;
        end
    end

    // post step overrides a write to the same pointer in one instruction
    always_ff @(posedge clk) begin
        if (reset) begin
            b_r <= 8'h00;
            x_r <= 8'h00;
            sp_r <= 8'h00;
        end else begin
            if (step_b) begin
                b_r <= b_r + step_d;
            end else if (wen && wa == `CCIS_B_LOC) begin
                b_r <= wd;
            end
            if (step_x) begin
                x_r <= x_r + step_d;
            end else if (wen && wa == `CCIS_X_LOC) begin
                x_r <= wd;
            end
            if (wen && wa == `CCIS_SP_LOC) begin
                sp_r <= wd;
            end
        end
    end

    // ----------------------------------------
    // program counter and skip
    // ----------------------------------------
    logic [14:0] pc_nxt;
    assign pc_nxt = {pch_r, pcl_r} + {13'h0000, pwdata[`CCIS_F_LEN]}
        + (skip ? {13'h0000, skl_r} : 15'h0000);

    always_ff @(posedge clk) begin
        if (reset) begin
            pch_r <= 7'h00;
            pcl_r <= 8'h00;
            skipped_r <= 1'b0;
        end else if (exec) begin
            {pch_r, pcl_r} <= pc_nxt;
            skipped_r <= skip;
        end else if (bus_wr && hit(paddr, `CCIS_PCL_ADDR)) begin
            pcl_r <= pwdata[7:0];
        end else if (bus_wr && hit(paddr, `CCIS_PCH_ADDR)) begin
            pch_r <= pwdata[6:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            madr_r <= 8'h00;
            skl_r <= 2'h1;
        end else if (bus_wr && hit(paddr, `CCIS_MADR_ADDR)) begin
            madr_r <= pwdata[7:0];
        end else if (bus_wr && hit(paddr, `CCIS_SKL_ADDR)) begin
            skl_r <= pwdata[`CCIS_F_SKL];
        end
    end

    // ----------------------------------------
    // apb slave: no wait states, data latched in setup
    // ----------------------------------------
    logic mapped;
    logic [31:0] rd_val;

    always_comb begin
        mapped = 1'b1;
        if (hit(paddr, `CCIS_CMD_ADDR)) begin
            rd_val = 32'h0000_0000;
        end else if (hit(paddr, `CCIS_ACC_ADDR)) begin
            rd_val = {24'h000000, acc_r};
        end else if (hit(paddr, `CCIS_FLG_ADDR)) begin
            rd_val = {28'h0000000, spnd_r, gie_r, hc_r, c_r};
        end else if (hit(paddr, `CCIS_PCL_ADDR)) begin
            rd_val = {24'h000000, pcl_r};
        end else if (hit(paddr, `CCIS_PCH_ADDR)) begin
            rd_val = {25'h0000000, pch_r};
        end else if (hit(paddr, `CCIS_MADR_ADDR)) begin
            rd_val = {24'h000000, madr_r};
        end else if (hit(paddr, `CCIS_MDAT_ADDR)) begin
            rd_val = {24'h000000, rd_mem(madr_r)};
        end else if (hit(paddr, `CCIS_SKL_ADDR)) begin
            rd_val = {30'h00000000, skl_r};
        end else if (hit(paddr, `CCIS_STAT_ADDR)) begin
            rd_val = {31'h00000000, skipped_r};
        end else begin
            rd_val = 32'h0000_0000;
            mapped = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable && !pready_r) begin
            pready_r <= 1'b1;
            pslverr_r <= !mapped;
            prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_add_result: assert property (@(posedge clk) disable iff (reset)
        exec && op == CCIS_OP_ADD |=> acc_r == 8'($past(acc_r) + $past(src_val)))
        else $error("add result wrong");

    a_adc_carry: assert property (@(posedge clk) disable iff (reset)
        exec && op == CCIS_OP_ADC |=> {c_r, acc_r} ==
        9'({1'b0, $past(acc_r)} + {1'b0, $past(src_val)} + {8'h00, $past(c_r)}))
        else $error("add with carry wrong");

    a_subtract_with_borrow_carry: assert property (@(posedge clk) disable iff (reset)
        exec && op == CCIS_OP_SUBTRACT_WITH_BORROW |=> {c_r, acc_r} ==
        9'({1'b0, $past(acc_r)} + {1'b0, ~$past(src_val)} + {8'h00, $past(c_r)}))
        else $error("subtract with carry wrong");

    a_skip_pc: assert property (@(posedge clk) disable iff (reset)
        exec && skip |=> {pch_r, pcl_r} == 15'($past({pch_r, pcl_r})
        + {13'h0000, $past(pwdata[`CCIS_F_LEN])} + {13'h0000, $past(skl_r)}))
        else $error("skip did not pass next instruction");

    a_greater_test: assert property (@(posedge clk) disable iff (reset)
        exec && op == CCIS_OP_TGT |=> skipped_r == !($past(acc_r) > $past(src_val)))
        else $error("greater test wrong");

    a_pend_clear: assert property (@(posedge clk) disable iff (reset)
        exec && op == CCIS_OP_CLRPND |=> !spnd_r)
        else $error("pending flag not cleared");

    a_load_step: assert property (@(posedge clk) disable iff (reset)
        step_b && !pwdata[`CCIS_F_DOWN] |=> b_r == 8'($past(b_r) + 8'h01))
        else $error("pointer not stepped");

    a_load_value: assert property (@(posedge clk) disable iff (reset)
        exec && op == CCIS_OP_LOAD |=> acc_r == $past(src_val))
        else $error("load value wrong");

    a_bus_answer: assert property (@(posedge clk) disable iff (reset)
        psel && !penable && !pready_r |=> pready_r ##1 !pready_r)
        else $error("apb answer timing wrong");
endmodule

// File: ccis_defines.svh
// constants for the instruction semantics core: bus map, fields, flag bits
`ifndef CCIS_DEFINES_SVH
`define CCIS_DEFINES_SVH

// ----------------------------------------
// apb byte addresses
// ----------------------------------------
`define CCIS_CMD_ADDR 12'h000
`define CCIS_ACC_ADDR 12'h004
`define CCIS_FLG_ADDR 12'h008
`define CCIS_PCL_ADDR 12'h00c
`define CCIS_PCH_ADDR 12'h010
`define CCIS_MADR_ADDR 12'h014
`define CCIS_MDAT_ADDR 12'h018
`define CCIS_SKL_ADDR 12'h01c
`define CCIS_STAT_ADDR 12'h020

// ----------------------------------------
// command word fields
// ----------------------------------------
`define CCIS_F_OP 3:0
`define CCIS_F_SRC 5:4
`define CCIS_F_ADR 15:8
`define CCIS_F_IMM 23:16
`define CCIS_F_BIT 26:24
`define CCIS_F_STEP 27
`define CCIS_F_DOWN 28
`define CCIS_F_LEN 30:29

// ----------------------------------------
// flags word bits and skip length field
// ----------------------------------------
`define CCIS_FLG_C 0
`define CCIS_FLG_HC 1
`define CCIS_FLG_GIE 2
`define CCIS_FLG_SPND 3
`define CCIS_F_SKL 1:0

// ----------------------------------------
// data memory locations
// ----------------------------------------
`define CCIS_X_LOC 8'hfc
`define CCIS_SP_LOC 8'hfd
`define CCIS_B_LOC 8'hfe
`define CCIS_REG_PAGE 4'hf

`endif

// File: ccis_pkg.sv
// types shared by the instruction semantics core
package ccis_pkg;
    typedef enum logic [3:0] {
        CCIS_OP_ADD = 4'h0,
        CCIS_OP_ADC = 4'h1,
        CCIS_OP_SUBTRACT_WITH_BORROW = 4'h2,
        CCIS_OP_AND = 4'h3,
        CCIS_OP_ANDSKIP = 4'h4,
        CCIS_OP_TEQ_MI = 4'h5,
        CCIS_OP_TEQ = 4'h6,
        CCIS_OP_TNE = 4'h7,
        CCIS_OP_TGT = 4'h8,
        CCIS_OP_TPTR = 4'h9,
        CCIS_OP_DSZ = 4'ha,
        CCIS_OP_SBIT = 4'hb,
        CCIS_OP_TBIT = 4'hc,
        CCIS_OP_CLRPND = 4'hd,
        CCIS_OP_XCH = 4'he,
        CCIS_OP_LOAD = 4'hf
    } ccis_op_t;

    typedef enum logic [1:0] {
        CCIS_SRC_DIRECT = 2'h0,
        CCIS_SRC_PTR_B = 2'h1,
        CCIS_SRC_IMM = 2'h2,
        CCIS_SRC_PTR_X = 2'h3
    } ccis_src_t;
endpackage

// File: ccis_alu.sv
// byte adder with carry in, optional subtract, carry and half carry out
`timescale 1ns/10ps
module ccis_alu (
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    input wire logic sub,
    output logic [7:0] sum,
    output logic cout,
    output logic hcout
);
    logic [7:0] bb;
    logic [8:0] full;
    logic [4:0] nib;

    // subtract is a + ~b + c, so carry set means no borrow
    always_comb begin
        bb = sub ? ~b : b;
        full = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
        nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
        sum = full[7:0];
        cout = full[8];
        hcout = nib[4];
    end
endmodule

// File: ccis_apb_master.sv
// apb master model that reaches the core's registers
`timescale 1ns/10ps
module ccis_apb_master (
    input wire logic clk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    // ----------------------------------------
    // bus transfer
    // ----------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // request held until pready is seen at an edge; the wait is bounded
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err, output logic ok);
        ok = 1'b0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge clk);
            ok = (pready === 1'b1);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data lines must not keep looking valid
        pwdata <= ~wd;
    endtask
endmodule

// File: ccis_core_tb.sv
// self-checking bench for the instruction semantics core
`timescale 1ns/10ps
`include "ccis_defines.svh"
module ccis_core_tb
    import ccis_pkg::*;
;
    typedef struct packed {
        logic [3:0] op;
        logic [1:0] src;
        logic [7:0] adr;
        logic [7:0] imm;
        logic [2:0] bn;
        logic [7:0] a;
        logic [3:0] f;
        logic [7:0] m;
        logic [7:0] ax;
        logic [3:0] fx;
        logic [7:0] mx;
        logic sk;
    } ccis_row_t;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic err, ok;
    int n_errors = 0;
    int n_checks = 0;

    // op src adr imm bit | acc flags mem | expected acc flags mem skipped
    ccis_row_t rows [29] = '{
        '{4'h0, 2'h2, 8'h20, 8'hc8, 3'h0, 8'h3c, 4'h1, 8'h00, 8'h04, 4'h1, 8'h00, 1'b0},
        '{4'h0, 2'h0, 8'h20, 8'h00, 3'h0, 8'h01, 4'h0, 8'h7f, 8'h80, 4'h0, 8'h7f, 1'b0},
        '{4'h1, 2'h0, 8'h20, 8'h00, 3'h0, 8'h0f, 4'h1, 8'h01, 8'h11, 4'h2, 8'h01, 1'b0},
        '{4'h1, 2'h2, 8'h20, 8'h10, 3'h0, 8'hf0, 4'h0, 8'h00, 8'h00, 4'h1, 8'h00, 1'b0},
        '{4'h2, 2'h2, 8'h20, 8'h01, 3'h0, 8'h18, 4'h1, 8'h00, 8'h17, 4'h3, 8'h00, 1'b0},
        '{4'h2, 2'h2, 8'h20, 8'h00, 3'h0, 8'h00, 4'h0, 8'h00, 8'hff, 4'h0, 8'h00, 1'b0},
        '{4'h4, 2'h2, 8'h20, 8'h0f, 3'h0, 8'h00, 4'h0, 8'h00, 8'h00, 4'h0, 8'h00, 1'b1},
        '{4'h4, 2'h2, 8'h20, 8'hff, 3'h0, 8'hff, 4'h0, 8'h00, 8'hff, 4'h0, 8'h00, 1'b0},
        '{4'h5, 2'h0, 8'h20, 8'h55, 3'h0, 8'h00, 4'h0, 8'h55, 8'h00, 4'h0, 8'h55, 1'b0},
        '{4'h5, 2'h0, 8'h20, 8'h54, 3'h0, 8'h54, 4'h0, 8'h55, 8'h54, 4'h0, 8'h55, 1'b1},
        '{4'h6, 2'h0, 8'h20, 8'h00, 3'h0, 8'h5a, 4'h0, 8'h5a, 8'h5a, 4'h0, 8'h5a, 1'b0},
        '{4'h6, 2'h2, 8'h20, 8'h5b, 3'h0, 8'h5a, 4'h0, 8'h5a, 8'h5a, 4'h0, 8'h5a, 1'b1},
        '{4'h7, 2'h2, 8'h20, 8'h01, 3'h0, 8'h01, 4'h0, 8'h00, 8'h01, 4'h0, 8'h00, 1'b1},
        '{4'h7, 2'h0, 8'h20, 8'h01, 3'h0, 8'h01, 4'h0, 8'h02, 8'h01, 4'h0, 8'h02, 1'b0},
        '{4'h8, 2'h2, 8'h20, 8'h7f, 3'h0, 8'h80, 4'h0, 8'h00, 8'h80, 4'h0, 8'h00, 1'b0},
        '{4'h8, 2'h2, 8'h20, 8'h80, 3'h0, 8'h80, 4'h0, 8'h00, 8'h80, 4'h0, 8'h00, 1'b1},
        '{4'h8, 2'h2, 8'h20, 8'h80, 3'h0, 8'h7f, 4'h0, 8'h00, 8'h7f, 4'h0, 8'h00, 1'b1},
        '{4'h9, 2'h2, 8'hfe, 8'h45, 3'h0, 8'h00, 4'h0, 8'h35, 8'h00, 4'h0, 8'h35, 1'b1},
        '{4'h9, 2'h2, 8'hfe, 8'ha6, 3'h0, 8'h00, 4'h0, 8'h35, 8'h00, 4'h0, 8'h35, 1'b0},
        '{4'ha, 2'h0, 8'hf3, 8'h00, 3'h0, 8'h00, 4'h0, 8'h01, 8'h00, 4'h0, 8'h00, 1'b1},
        '{4'ha, 2'h0, 8'hfb, 8'h00, 3'h0, 8'h00, 4'h0, 8'h00, 8'h00, 4'h0, 8'hff, 1'b0},
        '{4'hb, 2'h0, 8'h20, 8'h00, 3'h7, 8'h00, 4'h0, 8'h00, 8'h00, 4'h0, 8'h80, 1'b0},
        '{4'hb, 2'h0, 8'h20, 8'h00, 3'h0, 8'h00, 4'h0, 8'hfe, 8'h00, 4'h0, 8'hff, 1'b0},
        '{4'hc, 2'h0, 8'h20, 8'h00, 3'h4, 8'h00, 4'h0, 8'h10, 8'h00, 4'h0, 8'h10, 1'b0},
        '{4'hc, 2'h0, 8'h20, 8'h00, 3'h3, 8'h00, 4'h0, 8'h10, 8'h00, 4'h0, 8'h10, 1'b1},
        '{4'hc, 2'h2, 8'h20, 8'h00, 3'h1, 8'h02, 4'h0, 8'h00, 8'h02, 4'h0, 8'h00, 1'b0},
        '{4'hd, 2'h0, 8'h20, 8'h00, 3'h0, 8'h00, 4'hf, 8'h00, 8'h00, 4'h7, 8'h00, 1'b0},
        '{4'he, 2'h0, 8'h20, 8'h00, 3'h0, 8'h12, 4'h0, 8'h34, 8'h34, 4'h0, 8'h12, 1'b0},
        '{4'hf, 2'h2, 8'h20, 8'h9c, 3'h0, 8'h00, 4'h0, 8'h00, 8'h9c, 4'h0, 8'h00, 1'b0}
    };

    always #20 clk = ~clk;

    ccis_core #(.ADDR_W(12)) i_ccis_core (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    ccis_apb_master i_ccis_apb_master (.clk(clk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        i_ccis_apb_master.xfer(wr, a, d, rd, err, ok);
        if (!ok) begin
            n_errors++;
            $display("unexpected at %0t: pready seen %h expected %h", $time, 1'b0, 1'b1);
            finish_test();
        end
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    function automatic logic [31:0] cmd(input logic [3:0] op, input logic [1:0] s,
        input logic [7:0] a, input logic [7:0] i, input logic [2:0] b, input logic [1:0] ds,
        input logic [1:0] len);
        return {1'b0, len, ds, b, i, a, 2'b00, s, op};
    endfunction

    // pc low byte is cleared first so the skip shows as the distance travelled
    task automatic run_row(input ccis_row_t r);
        bus(1'b1, `CCIS_ACC_ADDR, {24'h0, r.a});
        bus(1'b1, `CCIS_FLG_ADDR, {28'h0, r.f});
        bus(1'b1, `CCIS_MADR_ADDR, {24'h0, r.adr});
        bus(1'b1, `CCIS_MDAT_ADDR, {24'h0, r.m});
        bus(1'b1, `CCIS_PCL_ADDR, 32'h0000_0000);
        bus(1'b1, `CCIS_CMD_ADDR, cmd(r.op, r.src, r.adr, r.imm, r.bn, 2'h0, 2'h1));
        rchk(`CCIS_ACC_ADDR, {24'h0, r.ax});
        rchk(`CCIS_FLG_ADDR, {28'h0, r.fx});
        rchk(`CCIS_MDAT_ADDR, {24'h0, r.mx});
        rchk(`CCIS_STAT_ADDR, {31'h0, r.sk});
        rchk(`CCIS_PCL_ADDR, {24'h0, r.sk ? 8'h03 : 8'h01});
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        bus(1'b1, `CCIS_SKL_ADDR, 32'h0000_0002);
        foreach (rows[k]) begin
            run_row(rows[k]);
        end
        // pointer forms with post step: b up then down, x down
        bus(1'b1, `CCIS_MADR_ADDR, 32'h0000_00fe);
        bus(1'b1, `CCIS_MDAT_ADDR, 32'h0000_0030);
        bus(1'b1, `CCIS_MADR_ADDR, 32'h0000_00fc);
        bus(1'b1, `CCIS_MDAT_ADDR, 32'h0000_0030);
        bus(1'b1, `CCIS_MADR_ADDR, 32'h0000_0031);
        bus(1'b1, `CCIS_MDAT_ADDR, 32'h0000_0066);
        bus(1'b1, `CCIS_MADR_ADDR, 32'h0000_0030);
        bus(1'b1, `CCIS_MDAT_ADDR, 32'h0000_0077);
        bus(1'b1, `CCIS_ACC_ADDR, 32'h0000_0011);
        bus(1'b1, `CCIS_CMD_ADDR, cmd(4'he, 2'h1, 8'h00, 8'h00, 3'h0, 2'h1, 2'h1));
        rchk(`CCIS_ACC_ADDR, 32'h0000_0077);
        rchk(`CCIS_MDAT_ADDR, 32'h0000_0011);
        bus(1'b1, `CCIS_CMD_ADDR, cmd(4'hf, 2'h1, 8'h00, 8'h00, 3'h0, 2'h3, 2'h1));
        rchk(`CCIS_ACC_ADDR, 32'h0000_0066);
        bus(1'b1, `CCIS_CMD_ADDR, cmd(4'hf, 2'h3, 8'h00, 8'h00, 3'h0, 2'h3, 2'h1));
        rchk(`CCIS_ACC_ADDR, 32'h0000_0011);
        bus(1'b1, `CCIS_MADR_ADDR, 32'h0000_00fe);
        rchk(`CCIS_MDAT_ADDR, 32'h0000_0030);
        bus(1'b1, `CCIS_MADR_ADDR, 32'h0000_00fc);
        rchk(`CCIS_MDAT_ADDR, 32'h0000_002f);
        // failed test at the top of the counter: wraps after len plus skip length
        bus(1'b1, `CCIS_PCH_ADDR, 32'h0000_00ff);
        rchk(`CCIS_PCH_ADDR, 32'h0000_007f);
        bus(1'b1, `CCIS_PCL_ADDR, 32'h0000_00ff);
        bus(1'b1, `CCIS_SKL_ADDR, 32'h0000_0003);
        bus(1'b1, `CCIS_ACC_ADDR, 32'hffff_ffff);
        rchk(`CCIS_ACC_ADDR, 32'h0000_00ff);
        bus(1'b1, `CCIS_CMD_ADDR, cmd(4'h7, 2'h2, 8'h00, 8'hff, 3'h0, 2'h0, 2'h2));
        rchk(`CCIS_PCL_ADDR, 32'h0000_0004);
        rchk(`CCIS_PCH_ADDR, 32'h0000_0000);
        bus(1'b1, `CCIS_FLG_ADDR, 32'h0000_00ff);
        rchk(`CCIS_FLG_ADDR, 32'h0000_000f);
        bus(1'b1, `CCIS_MADR_ADDR, 32'h0000_00fd);
        bus(1'b1, `CCIS_MDAT_ADDR, 32'h0000_01ab);
        rchk(`CCIS_MDAT_ADDR, 32'h0000_00ab);
        // unmapped place and write-only command word
        rchk(12'h024, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
        rchk(`CCIS_CMD_ADDR, 32'h0000_0000);
        // reset in mid-run brings back the documented starting state
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rchk(`CCIS_ACC_ADDR, 32'h0000_0000);
        rchk(`CCIS_FLG_ADDR, 32'h0000_0000);
        rchk(`CCIS_PCL_ADDR, 32'h0000_0000);
        rchk(`CCIS_SKL_ADDR, 32'h0000_0001);
        finish_test();
    end
endmodule
